// file: dv/pin_strap_config_capture_tb.sv
`timescale 1ns/10ps
`define CHECK(g, e) begin \
	total_checks++; \
	if ((g) !== (e)) begin \
		failures++; \
		$display("ERROR %0t: got %h exp %h", $time, g, e); \
	end \
end
module pin_strap_config_capture_tb
	import psc_pkg::*;
;
	logic        clk_i = 1'h0, reset_i = 1'h1;
	logic        wb_cyc = 1'h0, wb_stb = 1'h0, wb_we = 1'h0, wb_ack;
	logic [3:0]  wb_adr = 4'h0, wb_sel = 4'hf;
	logic [31:0] wb_wdat = 32'h0, wb_dato, rdat;
	logic [7:0]  rd_data = 8'h0, wr_data, d;
	logic [1:0]  sw_range = 2'h0, range;
	logic        int_ref, seq_en, seq_rs, sw_mode, burst, shut, full_p;
	logic        part_p, cfg_valid, if_inv, wr_valid;
	logic [5:0]  cfg, lat;
	logic [15:0] seed = 16'he97e;
	int          failures = 0, total_checks = 0, s, f;
	int          full_cnt = 0, part_cnt = 0, wrv_cnt = 0;
	always #10 clk_i = ~clk_i;
	always @(posedge clk_i) begin
		if (full_p === 1'b1) full_cnt++;
		if (part_p === 1'b1) part_cnt++;
		if (wr_valid === 1'b1) wrv_cnt++;
	end
	psc_link_if i_psc_link_if ();
	psc_device i_psc_device (.clk_i(clk_i), .reset_i(reset_i),
		.link(i_psc_link_if), .rd_data_i(rd_data), .sw_range_i(sw_range),
		.int_ref_enable_o(int_ref), .seq_enable_o(seq_en),
		.seq_restricted_o(seq_rs), .sw_mode_o(sw_mode),
		.burst_enable_o(burst), .range_o(range), .shutdown_o(shut),
		.full_reset_o(full_p), .partial_reset_o(part_p),
		.config_valid_o(cfg_valid), .if_invalid_o(if_inv),
		.wr_data_o(wr_data), .wr_valid_o(wr_valid));
	psc_host i_psc_host (.clk_i(clk_i), .reset_i(reset_i), .wb_cyc_i(wb_cyc),
		.wb_stb_i(wb_stb), .wb_we_i(wb_we), .wb_adr_i(wb_adr),
		.wb_sel_i(wb_sel), .wb_dat_i(wb_wdat), .wb_dat_o(wb_dato),
		.wb_ack_o(wb_ack), .link(i_psc_link_if));
	psc_link_monitor i_psc_link_monitor (.clk_i(clk_i), .reset_i(reset_i),
		.reset_n(i_psc_link_if.reset_n),
		.sequencer_enable_pin(i_psc_link_if.sequencer_enable_pin),
		.mode_range_select(i_psc_link_if.mode_range_select),
		.interface_select_n(i_psc_link_if.interface_select_n),
		.chip_select_n(i_psc_link_if.chip_select_n),
		.read_n(i_psc_link_if.read_n), .host_db_oe(i_psc_link_if.host_db_oe),
		.dev_db_oe(i_psc_link_if.dev_db_oe), .full_reset_o(full_p),
		.partial_reset_o(part_p), .shutdown_o(shut), .sw_mode_o(sw_mode),
		.seq_enable_o(seq_en), .seq_restricted_o(seq_rs),
		.burst_enable_o(burst), .range_o(range), .config_valid_o(cfg_valid));
	// ---------------------------------------------------------------
	// helpers
	// ---------------------------------------------------------------
	function logic [7:0] rnd();
		seed = {seed[14:0], seed[15] ^ seed[13] ^ seed[12] ^ seed[10]};
		return seed[7:0];
	endfunction : rnd
	function logic [1:0] exp_range(input logic [5:0] l, input logic [1:0] v);
		return (l[4:3] == 2'h0) ? sw_range : v;
	endfunction : exp_range
	function int cur(input int w);
		case (w)
			0: return full_cnt;
			1: return part_cnt;
			2: return wrv_cnt;
			default: return int'(shut === 1'b1);
		endcase
	endfunction : cur
	task complete_run;
		$display("checks %0d failures %0d", total_checks, failures);
		if (failures == 0 && total_checks > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask : complete_run
	task hang;
		failures++;
		$display("ERROR %0t: wait timed out", $time);
		complete_run();
	endtask : hang
	task wb(input logic we, input logic [3:0] a, input logic [31:0] dw);
		int n;
		@(posedge clk_i);
		wb_cyc  <= 1'b1;
		wb_stb  <= 1'b1;
		wb_we   <= we;
		wb_adr  <= a;
		wb_wdat <= dw;
		n = 0;
		do begin
			@(posedge clk_i);
			n++;
		end while (wb_ack !== 1'b1 && n < 40);
		if (n >= 40) hang();
		rdat = wb_dato;
		wb_cyc <= 1'b0;
		wb_stb <= 1'b0;
	endtask : wb
	task idle;
		int n;
		n = 0;
		do begin
			wb(1'b0, HREG_STATUS, 32'h0);
			n++;
		end while (rdat[STAT_BUSY_BIT] !== 1'b0 && n < 200);
		if (n >= 200) hang();
	endtask : idle
	task wait_chg(input int w, input int st);
		int n;
		n = 0;
		while (cur(w) == st && n < 1500) begin
			@(posedge clk_i);
			n++;
		end
		if (n >= 1500) hang();
	endtask : wait_chg
	task full(input logic [5:0] c);
		wb(1'b1, HREG_CFG, {26'h0, c});
		s = full_cnt;
		wb(1'b1, HREG_CMD, 32'h1);
		wait_chg(0, s);
		idle();
	endtask : full
	task check_state(input logic [5:0] l, input logic [1:0] v);
		logic hw;
		hw = (l[4:3] != 2'h0);
		`CHECK(int_ref, l[0]);
		`CHECK(sw_mode, !hw);
		`CHECK(seq_en, hw & l[1]);
		`CHECK(seq_rs, hw & l[1]);
		`CHECK(burst, hw & l[2]);
		`CHECK(range, exp_range(l, v));
		`CHECK(cfg_valid, 1'b1);
		`CHECK(if_inv, 1'b0);
	endtask : check_state
	// ---------------------------------------------------------------
	// main sequence
	// ---------------------------------------------------------------
	initial begin
		repeat (20) @(posedge clk_i);
		reset_i <= 1'b0;
		wb(1'b0, HREG_CFG, 32'h0);
		`CHECK(rdat[5:0], CFG_RESET);
		`CHECK(cfg_valid, 1'b0);
		wb(1'b0, 4'h2, 32'h0);
		`CHECK(rdat, 32'h0);
		$display("test reset done");
		for (int i = 0; i < 8; i++) begin
			d = rnd();
			cfg = {1'b0, i[1:0], d[2:0]};
			sw_range <= d[4:3];
			full(cfg);
			check_state(cfg, cfg[4:3]);
		end
		$display("test strap decode done");
		lat = cfg;
		wb(1'b1, HREG_CFG, {26'h0, 1'b0, 2'h1, ~lat[2:0]});
		idle();
		check_state(lat, 2'h1);
		s = part_cnt;
		f = full_cnt;
		wb(1'b1, HREG_CMD, 32'h2);
		wait_chg(1, s);
		idle();
		`CHECK(full_cnt, f);
		check_state(lat, 2'h1);
		$display("test latch and partial done");
		for (int k = 0; k < 4; k++) begin
			d = (k == 0) ? 8'h00 : (k == 1) ? 8'hff : rnd();
			rd_data <= d;
			wb(1'b1, HREG_CMD, 32'h4);
			idle();
			wb(1'b0, HREG_DATA, 32'h0);
			`CHECK(rdat[7:0], d);
		end
		$display("test bus read done");
		full(6'h02);
		check_state(6'h02, 2'h0);
		for (int k = 0; k < 2; k++) begin
			d = rnd();
			wb(1'b1, HREG_DATA, {24'h0, d});
			s = wrv_cnt;
			wb(1'b1, HREG_CMD, 32'h8);
			wait_chg(2, s);
			`CHECK(wr_data, d);
			idle();
		end
		$display("test bus write done");
		wb(1'b1, HREG_CFG, 32'h3d);
		wait_chg(3, 0);
		`CHECK(shut, 1'b1);
		s = full_cnt;
		wb(1'b1, HREG_CFG, 32'h1d);
		wait_chg(0, s);
		idle();
		`CHECK(shut, 1'b0);
		check_state(6'h1d, 2'h3);
		$display("test shutdown done");
		complete_run();
	end
endmodule : pin_strap_config_capture_tb

// file: dv/psc_link_monitor.sv
`timescale 1ns/10ps
module psc_link_monitor
	import psc_pkg::*;
#(
	parameter int PART_CYC = PART_MIN_CYC,
	parameter int FULL_CYC = FULL_MIN_CYC,
	parameter int SHUT_CYC = SHUT_MIN_CYC
) (
	input wire logic       clk_i,
	input wire logic       reset_i,
	input wire logic       reset_n,
	input wire logic       sequencer_enable_pin,
	input wire logic [1:0] mode_range_select,
	input wire logic       interface_select_n,
	input wire logic       chip_select_n,
	input wire logic       read_n,
	input wire logic       host_db_oe,
	input wire logic       dev_db_oe,
	input wire logic       full_reset_o,
	input wire logic       partial_reset_o,
	input wire logic       shutdown_o,
	input wire logic       sw_mode_o,
	input wire logic       seq_enable_o,
	input wire logic       seq_restricted_o,
	input wire logic       burst_enable_o,
	input wire logic [1:0] range_o,
	input wire logic       config_valid_o
);
	// ---------------------------------------------------------------
	// reset pulse length tracking
	// ---------------------------------------------------------------
	logic [CNT_W-1:0] low_run;
	logic [CNT_W-1:0] last_low;
	logic [3:0]       hi_run;
	wire logic        rd_sel;
	assign rd_sel = !chip_select_n && !read_n;
	always_ff @(posedge clk_i) begin
		if (reset_i) begin
			low_run  <= '0;
			last_low <= '0;
			hi_run   <= '0;
		end else if (!reset_n) begin
			low_run <= (&low_run) ? low_run : low_run + 1'b1;
			hi_run  <= '0;
		end else begin
			if (low_run != '0) last_low <= low_run;
			low_run <= '0;
			hi_run  <= (&hi_run) ? hi_run : hi_run + 1'b1;
		end
	end
	default clocking @(posedge clk_i); endclocking
	default disable iff (reset_i);
	// ---------------------------------------------------------------
	// checks
	// ---------------------------------------------------------------
	a_ifsel_low: assert property (interface_select_n == 1'b0)
		else $error("interface select driven high");
	a_seq_sw_low: assert property (
		mode_range_select == 2'h0 |-> !sequencer_enable_pin)
		else $error("sequencer strap high in software mode");
	a_bus_gate: assert property (
		dev_db_oe |-> $past(rd_sel, 2) || $past(rd_sel, 3))
		else $error("bus driven without select and read");
	a_oe_excl: assert property (!(dev_db_oe && host_db_oe))
		else $error("both ends drive the data lines");
	a_mode_latch: assert property (
		$changed(sw_mode_o) |-> full_reset_o || $past(full_reset_o))
		else $error("mode changed outside full reset");
	a_restrict_hw: assert property (
		seq_restricted_o |-> seq_enable_o && !sw_mode_o)
		else $error("restricted sequencer outside hardware mode");
	a_burst_hw: assert property (
		burst_enable_o |-> !sw_mode_o && config_valid_o)
		else $error("burst enabled outside hardware mode");
	a_range_live: assert property (
		(!sw_mode_o && config_valid_o && !shutdown_o && hi_run >= 4'h8
		&& mode_range_select != 2'h0 && $stable(mode_range_select))[*5]
		|-> range_o == mode_range_select)
		else $error("range does not follow strap");
	a_full_len: assert property (
		full_reset_o |-> last_low >= FULL_CYC)
		else $error("full reset on short pulse");
	a_part_len: assert property (
		partial_reset_o |-> last_low >= PART_CYC && last_low < FULL_CYC)
		else $error("partial reset on wrong pulse length");
	a_shut_len: assert property (
		$rose(shutdown_o) |-> !reset_n && low_run >= SHUT_CYC - 1)
		else $error("shutdown entered too early");
endmodule : psc_link_monitor

// file: pkg/psc_link_if.sv
`timescale 1ns/10ps
interface psc_link_if;
	logic       reset_n;
	logic       reference_source_select;
	logic       sequencer_enable_pin;
	logic [1:0] mode_range_select;
	logic       interface_select_n;
	logic       write_burst_pin;
	logic       chip_select_n;
	logic       read_n;
	logic [7:0] host_db_out;
	logic       host_db_oe;
	logic [7:0] dev_db_out;
	logic       dev_db_oe;
	logic [7:0] data_bus_low;

	// resolved level of the shared data lines
	assign data_bus_low = dev_db_oe  ? dev_db_out :
	                      host_db_oe ? host_db_out : 8'h00;

	modport device (
		input  reset_n, reference_source_select, sequencer_enable_pin,
		input  mode_range_select, interface_select_n, write_burst_pin,
		input  chip_select_n, read_n, data_bus_low,
		output dev_db_out, dev_db_oe
	);
	modport host (
		output reset_n, reference_source_select, sequencer_enable_pin,
		output mode_range_select, interface_select_n, write_burst_pin,
		output chip_select_n, read_n, host_db_out, host_db_oe,
		input  data_bus_low
	);
endinterface : psc_link_if

// file: pkg/psc_pkg.sv
package psc_pkg;
	// ---------------------------------------------------------------
	// clock and reset pulse timing
	// ---------------------------------------------------------------
	localparam int CLK_PERIOD_NS   = 20;
	localparam int PART_MIN_NS     = 50;
	localparam int FULL_MIN_NS     = 1200;
	localparam int SHUT_MIN_NS     = 20000;
	localparam int PART_MIN_CYC    =
		(PART_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int FULL_MIN_CYC    =
		(FULL_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int SHUT_MIN_CYC    =
		(SHUT_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int CNT_W           = 16;
	localparam int HOST_PART_CYC   = PART_MIN_CYC + 4;
	localparam int HOST_FULL_CYC   = FULL_MIN_CYC + 4;
	localparam int HOST_STROBE_CYC = 6;

	// ---------------------------------------------------------------
	// strap encodings
	// ---------------------------------------------------------------
	localparam logic [1:0] RANGE_SW    = 2'h0;
	localparam logic [1:0] RANGE_2V5   = 2'h1;
	localparam logic [1:0] RANGE_5V    = 2'h2;
	localparam logic [1:0] RANGE_10V   = 2'h3;
	localparam logic       IFSEL_PAR   = 1'h0;
	localparam int         DATA_W      = 8;

	// ---------------------------------------------------------------
	// host controller register map (byte addresses)
	// ---------------------------------------------------------------
	localparam logic [3:0] HREG_CFG    = 4'h0;
	localparam logic [3:0] HREG_CMD    = 4'h4;
	localparam logic [3:0] HREG_DATA   = 4'h8;
	localparam logic [3:0] HREG_STATUS = 4'hc;
	localparam int CFG_REF_BIT   = 0;
	localparam int CFG_SEQ_BIT   = 1;
	localparam int CFG_BURST_BIT = 2;
	localparam int CFG_RANGE_LO  = 3;
	localparam int CFG_SHUT_BIT  = 5;
	localparam logic [5:0] CFG_RESET = 6'h01;
	localparam int CMD_FULL_BIT  = 0;
	localparam int CMD_PART_BIT  = 1;
	localparam int CMD_READ_BIT  = 2;
	localparam int CMD_WRITE_BIT = 3;
	localparam int STAT_BUSY_BIT = 0;
	localparam int STAT_SHUT_BIT = 1;
endpackage : psc_pkg

// file: src/psc_device.sv
// Contract
// - high reference select enables internal reference
// - low select: host supplies external reference
// - reference, sequencer straps latched at full reset
// - low pulse length picks full or partial
// - reset held low means shutdown
// - hardware mode, low strap disables sequencer
// - high strap enables sequencer, restricted in hardware
// - software mode: host ties sequencer strap low
// - hardware/software mode latched at full reset
// - hardware range follows strap continuously
// - code 00 at release means software mode
// - 01 2.5V, 10 5V, 11 10V
// - host drives interface select low early
// - interface select 0 parallel, 1 invalid
// - low data byte is bidirectional bus
// - drive bus only when select, read low
// - hardware mode burst strap latched at full reset
//
// The Wishbone slave port and the register addresses are this design's own decisions.
`timescale 1ns/10ps
module psc_device
	import psc_pkg::*;
#(
	parameter int PART_CYC = PART_MIN_CYC,
	parameter int FULL_CYC = FULL_MIN_CYC,
	parameter int SHUT_CYC = SHUT_MIN_CYC
) (
	input  wire logic             clk_i,
	input  wire logic             reset_i,
	psc_link_if.device            link,
	input  wire logic [DATA_W-1:0] rd_data_i,
	input  wire logic [1:0]       sw_range_i,
	output logic                  int_ref_enable_o,
	output logic                  seq_enable_o,
	output logic                  seq_restricted_o,
	output logic                  sw_mode_o,
	output logic                  burst_enable_o,
	output logic [1:0]            range_o,
	output logic                  shutdown_o,
	output logic                  full_reset_o,
	output logic                  partial_reset_o,
	output logic                  config_valid_o,
	output logic                  if_invalid_o,
	output logic [DATA_W-1:0]     wr_data_o,
	output logic                  wr_valid_o
);
	typedef enum logic [1:0] {
		PSC_RUN,
		PSC_LOW,
		PSC_SHUT
	} psc_state_e;

	// ---------------------------------------------------------------
	// pin synchronisers
	// ---------------------------------------------------------------
	logic [7:0]        pins_meta_reg;
	logic [7:0]        pins_sync_reg;
	logic [DATA_W-1:0] db_meta_reg;
	logic [DATA_W-1:0] db_sync_reg;
	wire  [7:0]        pins_raw;
	wire               rst_n_s;
	wire               ref_s;
	wire               seq_s;
	wire  [1:0]        range_s;
	wire               ifsel_s;
	wire               wrb_s;
	wire               cs_n_s;
	wire               rd_n_s;

	assign pins_raw = {link.read_n, link.chip_select_n,
	                   link.write_burst_pin, link.interface_select_n,
	                   link.mode_range_select, link.sequencer_enable_pin,
	                   link.reference_source_select};
	assign ref_s    = pins_sync_reg[0];
	assign seq_s    = pins_sync_reg[1];
	assign range_s  = pins_sync_reg[3:2];
	assign ifsel_s  = pins_sync_reg[4];
	assign wrb_s    = pins_sync_reg[5];
	assign cs_n_s   = pins_sync_reg[6];
	assign rd_n_s   = pins_sync_reg[7];

	logic rst_meta_reg;
	logic rst_sync_reg;
	assign rst_n_s = rst_sync_reg;

	always_ff @(posedge clk_i) begin
		if (reset_i) begin
			pins_meta_reg <= 8'hc0;
			pins_sync_reg <= 8'hc0;
			rst_meta_reg  <= 1'b1;
			rst_sync_reg  <= 1'b1;
			db_meta_reg   <= '0;
			db_sync_reg   <= '0;
		end else begin
			pins_meta_reg <= pins_raw;
			pins_sync_reg <= pins_meta_reg;
			rst_meta_reg  <= link.reset_n;
			rst_sync_reg  <= rst_meta_reg;
			db_meta_reg   <= link.data_bus_low;
			db_sync_reg   <= db_meta_reg;
		end
	end

	// ---------------------------------------------------------------
	// reset pulse classifier
	// ---------------------------------------------------------------
	psc_state_e        state_reg;
	psc_state_e        state_next;
	logic [CNT_W-1:0]  low_cnt_reg;
	wire               released;
	wire               is_full;
	wire               is_part;
	wire               hit_shut;
	wire               full_rel;

	assign released = rst_n_s;
	assign hit_shut = (low_cnt_reg >= CNT_W'(SHUT_CYC - 1));
	assign is_full  = (low_cnt_reg >= CNT_W'(FULL_CYC));
	assign is_part  = (low_cnt_reg >= CNT_W'(PART_CYC));
	assign full_rel = released &&
	                  ((state_reg == PSC_SHUT) ||
	                   (state_reg == PSC_LOW && is_full));

	always_comb begin
		state_next = state_reg;
		case (state_reg)
			PSC_RUN:  if (!rst_n_s) state_next = PSC_LOW;
			PSC_LOW: begin
				if (released)
					state_next = PSC_RUN;
				else if (hit_shut)
					state_next = PSC_SHUT;
			end
			PSC_SHUT: if (released) state_next = PSC_RUN;
			default:  state_next = PSC_RUN;
		endcase
	end

	always_ff @(posedge clk_i) begin
		if (reset_i) begin
			state_reg   <= PSC_RUN;
			low_cnt_reg <= '0;
		end else begin
			state_reg <= state_next;
			// count from the first low cycle so n low cycles reads n
			if (!released && state_reg != PSC_SHUT)
				low_cnt_reg <= low_cnt_reg + CNT_W'(1);
			else if (state_reg != PSC_SHUT)
				low_cnt_reg <= '0;
		end
	end

	always_ff @(posedge clk_i) begin
		if (reset_i) begin
			full_reset_o    <= 1'b0;
			partial_reset_o <= 1'b0;
			shutdown_o      <= 1'b0;
		end else begin
			full_reset_o    <= full_rel;
			partial_reset_o <= released && state_reg == PSC_LOW &&
			                   is_part && !is_full;
			shutdown_o      <= (state_next == PSC_SHUT);
		end
	end

	// ---------------------------------------------------------------
	// strap capture at full reset release
	// ---------------------------------------------------------------
	logic ref_reg;
	logic seq_reg;
	logic sw_reg;
	logic burst_reg;
	logic valid_reg;
	logic ifbad_reg;

	always_ff @(posedge clk_i) begin
		if (reset_i) begin
			ref_reg   <= 1'b0;
			seq_reg   <= 1'b0;
			sw_reg    <= 1'b0;
			burst_reg <= 1'b0;
			valid_reg <= 1'b0;
			ifbad_reg <= 1'b0;
		end else if (full_rel) begin
			ref_reg   <= ref_s;
			seq_reg   <= seq_s;
			sw_reg    <= (range_s == RANGE_SW);
			burst_reg <= (range_s != RANGE_SW) && wrb_s;
			valid_reg <= 1'b1;
			ifbad_reg <= (ifsel_s != IFSEL_PAR);
		end
	end

	wire active;
	assign active = valid_reg && state_reg == PSC_RUN;

	assign int_ref_enable_o = active && ref_reg;
	assign seq_enable_o     = active && seq_reg;
	assign seq_restricted_o = active && seq_reg && !sw_reg;
	assign sw_mode_o        = sw_reg;
	assign burst_enable_o   = active && burst_reg;
	assign config_valid_o   = valid_reg;
	assign if_invalid_o     = ifbad_reg;

	// hardware mode tracks the strap live; software mode follows the sw_range_i input
	always_ff @(posedge clk_i) begin
		if (reset_i)
			range_o <= RANGE_SW;
		else if (sw_reg)
			range_o <= sw_range_i;
		else
			range_o <= range_s;
	end

	// ---------------------------------------------------------------
	// parallel data lines
	// ---------------------------------------------------------------
	logic [DATA_W-1:0] dout_reg;
	logic              wr_low_reg;
	wire               par_ok;
	wire               wr_strobe;

	assign par_ok        = active && !ifbad_reg;
	assign link.dev_db_oe  = par_ok && !cs_n_s && !rd_n_s;
	assign link.dev_db_out = dout_reg;
	assign wr_strobe     = sw_reg && par_ok && !cs_n_s && !wrb_s;

	always_ff @(posedge clk_i) begin
		if (reset_i) begin
			dout_reg   <= '0;
			wr_low_reg <= 1'b0;
			wr_data_o  <= '0;
			wr_valid_o <= 1'b0;
		end else begin
			dout_reg   <= rd_data_i;
			wr_low_reg <= wr_strobe;
			wr_valid_o <= wr_low_reg && !wr_strobe;
			if (wr_strobe)
				wr_data_o <= db_sync_reg;
		end
	end
endmodule : psc_device

// file: src/psc_host.sv
`timescale 1ns/10ps
module psc_host
	import psc_pkg::*;
(
	input  wire logic        clk_i,
	input  wire logic        reset_i,
	input  wire logic        wb_cyc_i,
	input  wire logic        wb_stb_i,
	input  wire logic        wb_we_i,
	input  wire logic [3:0]  wb_adr_i,
	input  wire logic [3:0]  wb_sel_i,
	input  wire logic [31:0] wb_dat_i,
	output logic      [31:0] wb_dat_o,
	output logic             wb_ack_o,
	psc_link_if.host         link
);
	typedef enum logic [2:0] {
		PSH_IDLE,
		PSH_RST,
		PSH_RD,
		PSH_WR
	} psc_host_state_e;

	// ---------------------------------------------------------------
	// wishbone slave
	// ---------------------------------------------------------------
	logic [5:0]        cfg_reg;
	logic [7:0]        wdata_reg;
	logic [7:0]        rdata_reg;
	psc_host_state_e   state_reg;
	logic [CNT_W-1:0]  cnt_reg;
	wire               req;
	wire               wr_cfg;
	wire               wr_cmd;
	wire               wr_dat;
	wire               busy;
	wire               sw_mode;
	wire [31:0]        rd_mux;

	assign req     = wb_cyc_i && wb_stb_i && !wb_ack_o;
	assign wr_cfg  = req && wb_we_i && wb_sel_i[0] && wb_adr_i == HREG_CFG;
	assign wr_cmd  = req && wb_we_i && wb_sel_i[0] && wb_adr_i == HREG_CMD;
	assign wr_dat  = req && wb_we_i && wb_sel_i[0] && wb_adr_i == HREG_DATA;
	assign busy    = (state_reg != PSH_IDLE);
	assign sw_mode = (cfg_reg[CFG_RANGE_LO +: 2] == RANGE_SW);
	assign rd_mux  = (wb_adr_i == HREG_CFG)    ? {26'h0, cfg_reg} :
	                 (wb_adr_i == HREG_DATA)   ? {24'h0, rdata_reg} :
	                 (wb_adr_i == HREG_STATUS) ?
	                   {30'h0, cfg_reg[CFG_SHUT_BIT], busy} : 32'h0;

	always_ff @(posedge clk_i) begin
		if (reset_i) begin
			wb_ack_o  <= 1'b0;
			wb_dat_o  <= '0;
			cfg_reg   <= CFG_RESET;
			wdata_reg <= '0;
		end else begin
			wb_ack_o <= req;
			wb_dat_o <= req ? rd_mux : 32'h0;
			if (wr_cfg)
				cfg_reg <= wb_dat_i[5:0];
			if (wr_dat)
				wdata_reg <= wb_dat_i[7:0];
		end
	end

	// ---------------------------------------------------------------
	// link sequencer
	// ---------------------------------------------------------------
	logic [7:0] db_meta_reg;
	logic [7:0] db_sync_reg;
	logic       rst_n_reg;
	logic       cs_n_reg;
	logic       rd_n_reg;
	logic       wr_n_reg;
	logic       oe_reg;
	wire        go_full;
	wire        go_part;
	wire        go_rd;
	wire        go_wr;
	wire        done;

	assign go_full = wr_cmd && wb_dat_i[CMD_FULL_BIT];
	assign go_part = wr_cmd && wb_dat_i[CMD_PART_BIT];
	assign go_rd   = wr_cmd && wb_dat_i[CMD_READ_BIT];
	assign go_wr   = wr_cmd && wb_dat_i[CMD_WRITE_BIT] && sw_mode;
	assign done    = (cnt_reg == CNT_W'(1));

	always_ff @(posedge clk_i) begin
		if (reset_i) begin
			state_reg   <= PSH_IDLE;
			cnt_reg     <= '0;
			rst_n_reg   <= 1'b1;
			cs_n_reg    <= 1'b1;
			rd_n_reg    <= 1'b1;
			wr_n_reg    <= 1'b1;
			oe_reg      <= 1'b0;
			rdata_reg   <= '0;
			db_meta_reg <= '0;
			db_sync_reg <= '0;
		end else begin
			db_meta_reg <= link.data_bus_low;
			db_sync_reg <= db_meta_reg;
			case (state_reg)
				PSH_IDLE: begin
					if (go_full || go_part) begin
						state_reg <= PSH_RST;
						rst_n_reg <= 1'b0;
						cnt_reg   <= go_full ? CNT_W'(HOST_FULL_CYC) :
						                       CNT_W'(HOST_PART_CYC);
					end else if (go_rd) begin
						state_reg <= PSH_RD;
						cs_n_reg  <= 1'b0;
						rd_n_reg  <= 1'b0;
						cnt_reg   <= CNT_W'(HOST_STROBE_CYC);
					end else if (go_wr) begin
						state_reg <= PSH_WR;
						cs_n_reg  <= 1'b0;
						wr_n_reg  <= 1'b0;
						oe_reg    <= 1'b1;
						cnt_reg   <= CNT_W'(HOST_STROBE_CYC);
					end
				end
				PSH_RST: begin
					cnt_reg <= cnt_reg - CNT_W'(1);
					if (done) begin
						state_reg <= PSH_IDLE;
						rst_n_reg <= 1'b1;
					end
				end
				PSH_RD: begin
					cnt_reg <= cnt_reg - CNT_W'(1);
					if (done) begin
						state_reg <= PSH_IDLE;
						rdata_reg <= db_sync_reg;
						cs_n_reg  <= 1'b1;
						rd_n_reg  <= 1'b1;
					end
				end
				PSH_WR: begin
					cnt_reg <= cnt_reg - CNT_W'(1);
					if (done) begin
						state_reg <= PSH_IDLE;
						cs_n_reg  <= 1'b1;
						wr_n_reg  <= 1'b1;
						oe_reg    <= 1'b0;
					end
				end
				default: state_reg <= PSH_IDLE;
			endcase
		end
	end

	// ---------------------------------------------------------------
	// pin drive
	// ---------------------------------------------------------------
	assign link.reset_n                 = rst_n_reg && !cfg_reg[CFG_SHUT_BIT];
	assign link.reference_source_select = cfg_reg[CFG_REF_BIT];
	assign link.sequencer_enable_pin    = cfg_reg[CFG_SEQ_BIT] &&
	                                      !sw_mode;
	assign link.mode_range_select       = cfg_reg[CFG_RANGE_LO +: 2];
	assign link.interface_select_n      = IFSEL_PAR;
	assign link.write_burst_pin         = sw_mode ? wr_n_reg :
	                                      cfg_reg[CFG_BURST_BIT];
	assign link.chip_select_n           = cs_n_reg;
	assign link.read_n                  = rd_n_reg;
	assign link.host_db_out             = wdata_reg;
	assign link.host_db_oe              = oe_reg;
endmodule : psc_host
